//--- src/cmd_decode.v
// command word decoder: key check and command classification
// assumes the word is the one written at the command offset
`timescale 1ns/1ps
`default_nettype none
`include "fuse_lock_defines.vh"
module cmd_decode (
	input wire [31:0] word,
	output reg key_ok,
	output reg known,
	output reg [5:0] code,
	output reg [15:0] page_number_field
);
	always @* begin
		code = word[`CMD_MSB:`CMD_LSB];
		page_number_field = word[`PAGE_NUMBER_FIELD_MSB:`PAGE_NUMBER_FIELD_LSB];
		key_ok = (word[`KEY_MSB:`KEY_LSB] == `CMD_KEY);
		known = (code <= `CMD_FUSE_ERASE_ALL);
	end
endmodule
`default_nettype wire

//--- src/fuse_lock_ctrl.v
// region-lock and general-purpose fuse command logic
// assumes a single-cycle register port on SYS_CLK, no wait states
// Overview of operation
// - sixteen regions, locked region refuses page changes
// - lock/unlock command alters region of page
// - bad key or command sets programming error
// - lock bits are fuses 15:0, one unlocked
// - lock commands and fuse bit commands equal
// - all fuse bits readable by software
// - fuse 16 drives external fetch lock
// - security bit blocks fetch lock changes
// - fuses 19:17 select boot area size
// - decode 7 none down to 0 128 pages
// - security bit blocks boot field changes
// - fuses 21:20 encode secure state
// - fuse 22 enables user protection
// - fuse bit program or erase one bit
// - byte command: index 2:0, value 10:3
// - byte 2 refused while security set
// - erase all fuses, refused while secured
// - secured fuse 16, 19:17 or 22 change sets lock error
// - secure fuse change in secure mode errors
// - protected page change sets lock error
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fuse_lock_defines.vh"
module fuse_lock_ctrl (
	input wire SYS_CLK,
	input wire RST_N,
	input wire [7:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	input wire SECURITY_SET,
	output reg [31:0] RDATA,
	output reg EXT_FETCH_LOCK,
	output reg [2:0] BOOT_AREA,
	output reg SECURE_EN,
	output reg SECURE_DEBUG_EN,
	output reg USER_PROT_EN,
	output reg PAGE_OP,
	output reg [15:0] PAGE_OP_NUM,
	output reg PAGE_OP_ERASE
);
	localparam S_IDLE = 2'b01;
	localparam S_EXEC = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [63:0] fuse_q;
	reg [63:0] fuse_d;
	reg lock_error_flag_q;
	reg programming_error_flag_q;
	reg [5:0] code_q;
	reg [15:0] page_number_field_q;
	reg sec_meta_q;
	reg sec_q;
	reg set_lock_error_flag;
	reg do_page;

	wire key_ok;
	wire known;
	wire [5:0] code;
	wire [15:0] page_number_field;
	wire page_blocked;
	wire secure_mode;
	wire cmd_wr;
	wire st_rd;

	cmd_decode u_dec (
		.word(WDATA),
		.key_ok(key_ok),
		.known(known),
		.code(code),
		.page_number_field(page_number_field)
	);

	// protection uses the live fuse word
	page_guard u_guard (
		.fuses(fuse_q),
		.page(page_number_field_q),
		.blocked(page_blocked)
	);

	assign cmd_wr = WR && (ADDR == `OFS_CMD);
	assign st_rd = RD && (ADDR == `OFS_STATUS);
	assign secure_mode = fuse_q[`SEC_MSB] ^ fuse_q[`SEC_LSB];

	// six-bit copies of the special fuse positions, for index compares
	localparam [5:0] IDX_EXT_FETCH_LOCK_FUSE = `EXT_FETCH_LOCK_FUSE_BIT;
	localparam [5:0] IDX_USER_PROTECTION_FUSE = `USER_PROTECTION_FUSE_BIT;
	localparam [5:0] IDX_SEC_HI = `SEC_MSB;
	localparam [5:0] IDX_SEC_LO = `SEC_LSB;

	function sec_field;
		input [5:0] idx;
		begin
			sec_field = (idx == IDX_SEC_HI) || (idx == IDX_SEC_LO);
		end
	endfunction

	// true when fuse index hits a field closed by the security bit
	function guarded;
		input [5:0] idx;
		begin
			guarded = (idx >= IDX_EXT_FETCH_LOCK_FUSE) && (idx <= IDX_USER_PROTECTION_FUSE) &&
				!sec_field(idx);
		end
	endfunction

	// lock fuse index of the region that holds a page
	function [5:0] region_of;
		input [15:0] page;
		begin
			region_of = {2'b00, page[`PAGE_BITS-1:`REGION_SHIFT]};
		end
	endfunction

	function [63:0] put_byte;
		input [63:0] v;
		input [2:0] sel;
		input [7:0] val;
		reg [63:0] r;
		begin
			r = v;
			case (sel)
			3'h0: r[7:0] = val;
			3'h1: r[15:8] = val;
			3'h2: r[23:16] = val;
			3'h3: r[31:24] = val;
			3'h4: r[39:32] = val;
			3'h5: r[47:40] = val;
			3'h6: r[55:48] = val;
			default: r[63:56] = val;
			endcase
			put_byte = r;
		end
	endfunction

	function [31:0] status_word;
		input ready;
		input lock_err;
		input prog_err;
		input secured;
		input [15:0] lock;
		reg [31:0] w;
		begin
			w = 32'h00000000;
			w[`ST_READY_BIT] = ready;
			w[`ST_LOCK_ERROR_FLAG_BIT] = lock_err;
			w[`ST_PROGRAMMING_ERROR_FLAG_BIT] = prog_err;
			w[`ST_SECURE_BIT] = secured;
			w[31:16] = lock;
			status_word = w;
		end
	endfunction

	// the key field always reads back as zero
	function [31:0] cmd_readback;
		input [15:0] page;
		input [5:0] op;
		begin
			cmd_readback = {8'h00, page, 2'b00, op};
		end
	endfunction

	function [63:0] set_bit;
		input [63:0] v;
		input [5:0] idx;
		input val;
		reg [63:0] r;
		begin
			r = v;
			r[idx] = val;
			set_bit = r;
		end
	endfunction

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sec_meta_q <= 1'b0;
			sec_q <= 1'b0;
		end else begin
			sec_meta_q <= SECURITY_SET;
			sec_q <= sec_meta_q;
		end
	end

	always @* begin
		state_d = state_q;
		fuse_d = fuse_q;
		set_lock_error_flag = 1'b0;
		do_page = 1'b0;
		case (state_q)
		S_IDLE: begin
			if (cmd_wr && key_ok && known) begin
				state_d = S_EXEC;
			end
		end
		S_EXEC: begin
			state_d = S_IDLE;
			case (code_q)
			`CMD_WRITE_PAGE, `CMD_ERASE_PAGE: begin
				if (page_blocked) begin
					set_lock_error_flag = 1'b1;
				end else begin
					do_page = 1'b1;
				end
			end
			`CMD_LOCK: begin
				// region index is the page's upper bits
				fuse_d = set_bit(fuse_q, region_of(page_number_field_q), 1'b0);
			end
			`CMD_UNLOCK: begin
				fuse_d = set_bit(fuse_q, region_of(page_number_field_q), 1'b1);
			end
			`CMD_FUSE_BIT_PROGRAM, `CMD_FUSE_BIT_ERASE: begin
				if (sec_q && guarded(page_number_field_q[5:0])) begin
					set_lock_error_flag = 1'b1;
				end else if (secure_mode && sec_field(page_number_field_q[5:0])) begin
					set_lock_error_flag = 1'b1;
				end else begin
					// program writes zero, erase writes one
					fuse_d = set_bit(fuse_q, page_number_field_q[5:0],
						code_q == `CMD_FUSE_BIT_ERASE);
				end
			end
			`CMD_FUSE_BYTE_PROGRAM: begin
				if (sec_q && (page_number_field_q[2:0] == 3'h2)) begin
					set_lock_error_flag = 1'b1;
				end else if (secure_mode && (page_number_field_q[2:0] == 3'h2)) begin
					set_lock_error_flag = 1'b1;
				end else begin
					fuse_d = put_byte(fuse_q, page_number_field_q[2:0],
						page_number_field_q[10:3]);
				end
			end
			`CMD_FUSE_ERASE_ALL: begin
				if (sec_q || secure_mode) begin
					set_lock_error_flag = 1'b1;
				end else begin
					fuse_d = `FUSE_RESET;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
			endcase
		end
		default: begin
			state_d = S_IDLE;
		end
		endcase
	end

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= S_IDLE;
			fuse_q <= `FUSE_RESET;
			lock_error_flag_q <= 1'b0;
			programming_error_flag_q <= 1'b0;
			code_q <= `CMD_NOP;
			page_number_field_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			fuse_q <= fuse_d;
			if (cmd_wr && (state_q == S_IDLE)) begin
				code_q <= code;
				page_number_field_q <= page_number_field;
			end
			// setting wins over the read clear
			if (cmd_wr && (!key_ok || !known || (state_q != S_IDLE))) begin
				programming_error_flag_q <= 1'b1;
			end else if (st_rd) begin
				programming_error_flag_q <= 1'b0;
			end
			if (set_lock_error_flag) begin
				lock_error_flag_q <= 1'b1;
			end else if (st_rd) begin
				lock_error_flag_q <= 1'b0;
			end
		end
	end

	// decoded fuse outputs follow fuse_d, so they move with the fuse
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			EXT_FETCH_LOCK <= 1'b1;
			BOOT_AREA <= 3'h7;
			SECURE_EN <= 1'b0;
			SECURE_DEBUG_EN <= 1'b0;
			USER_PROT_EN <= 1'b0;
		end else begin
			EXT_FETCH_LOCK <= fuse_d[`EXT_FETCH_LOCK_FUSE_BIT];
			BOOT_AREA <= fuse_d[`BOOT_MSB:`BOOT_LSB];
			SECURE_EN <= fuse_d[`SEC_MSB] ^ fuse_d[`SEC_LSB];
			SECURE_DEBUG_EN <= !fuse_d[`SEC_MSB] && fuse_d[`SEC_LSB];
			USER_PROT_EN <= fuse_d[`USER_PROTECTION_FUSE_BIT];
		end
	end

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PAGE_OP <= 1'b0;
			PAGE_OP_NUM <= 16'h0000;
			PAGE_OP_ERASE <= 1'b0;
		end else begin
			PAGE_OP <= do_page;
			PAGE_OP_NUM <= page_number_field_q;
			PAGE_OP_ERASE <= (code_q == `CMD_ERASE_PAGE);
		end
	end

	// read data stand one cycle after the strobe, zero otherwise
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= 32'h00000000;
		end else if (RD) begin
			case (ADDR)
			`OFS_STATUS: RDATA <= status_word(state_q == S_IDLE, lock_error_flag_q,
				programming_error_flag_q, sec_q, fuse_q[15:0]);
			`OFS_CMD: RDATA <= cmd_readback(page_number_field_q, code_q);
			`OFS_FUSE_HI: RDATA <= fuse_q[63:32];
			`OFS_FUSE_LO: RDATA <= fuse_q[31:0];
			default: RDATA <= 32'h00000000;
			endcase
		end else begin
			RDATA <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

//--- src/fuse_lock_defines.vh
// constants for the region-lock and general-purpose fuse logic
// assumes a 64-bit fuse array and 32-bit register port
`ifndef FUSE_LOCK_DEFINES_VH
`define FUSE_LOCK_DEFINES_VH

`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_FUSE_HI 8'h14
`define OFS_FUSE_LO 8'h18
`define OFS_SECURITY 8'h40
`define OFS_PAGE_CMD 8'h44

`define CMD_KEY 8'hA5
`define KEY_MSB 31
`define KEY_LSB 24
`define PAGE_NUMBER_FIELD_MSB 23
`define PAGE_NUMBER_FIELD_LSB 8
`define CMD_MSB 5
`define CMD_LSB 0

`define CMD_NOP 6'h00
`define CMD_WRITE_PAGE 6'h01
`define CMD_ERASE_PAGE 6'h02
`define CMD_CLEAR_BUF 6'h03
`define CMD_LOCK 6'h04
`define CMD_UNLOCK 6'h05
`define CMD_ERASE_ALL 6'h06
`define CMD_FUSE_BIT_PROGRAM 6'h07
`define CMD_FUSE_BIT_ERASE 6'h08
`define CMD_SET_SECURITY 6'h09
`define CMD_FUSE_BYTE_PROGRAM 6'h0A
`define CMD_FUSE_ERASE_ALL 6'h0B

`define FUSE_RESET 64'hFFFFFFFFFFFFFFFF
`define EXT_FETCH_LOCK_FUSE_BIT 16
`define BOOT_MSB 19
`define BOOT_LSB 17
`define SEC_MSB 21
`define SEC_LSB 20
`define USER_PROTECTION_FUSE_BIT 22

`define ST_LOCK_ERROR_FLAG_BIT 2
`define ST_PROGRAMMING_ERROR_FLAG_BIT 3
`define ST_READY_BIT 0
`define ST_SECURE_BIT 4

`define PAGE_BITS 10
`define REGION_SHIFT 6

`endif

//--- src/page_guard.v
// page protection check for page write or erase
// assumes fuse word and page number from the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "fuse_lock_defines.vh"
module page_guard (
	input wire [63:0] fuses,
	input wire [15:0] page,
	output reg blocked
);
	reg [3:0] region;
	reg [7:0] limit;
	always @* begin
		region = page[`PAGE_BITS-1:`REGION_SHIFT];
		// boot area: 7 none, 6 two pages, each step down doubles
		case (fuses[`BOOT_MSB:`BOOT_LSB])
		3'h7: limit = 8'h00;
		3'h6: limit = 8'h02;
		3'h5: limit = 8'h04;
		3'h4: limit = 8'h08;
		3'h3: limit = 8'h10;
		3'h2: limit = 8'h20;
		3'h1: limit = 8'h40;
		default: limit = 8'h80;
		endcase
		blocked = (fuses[region] == 1'b0) ||
			((page[15:8] == 8'h00) && (page[7:0] < limit));
	end
endmodule
`default_nettype wire

//--- tb/fuse_lock_chk.sv
// port checker for fuse_lock_ctrl
// assumes one clock and the active-low asynchronous reset of the block
`timescale 1ns/1ps
`default_nettype none
module fuse_lock_chk (
	input wire SYS_CLK,
	input wire RST_N,
	input wire [7:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	input wire SECURITY_SET,
	input wire [31:0] RDATA,
	input wire EXT_FETCH_LOCK,
	input wire [2:0] BOOT_AREA,
	input wire SECURE_EN,
	input wire SECURE_DEBUG_EN,
	input wire USER_PROT_EN,
	input wire PAGE_OP,
	input wire [15:0] PAGE_OP_NUM,
	input wire PAGE_OP_ERASE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	logic [31:0] wd_q;
	logic [31:0] wd2_q;
	// write data of the command that a page pulse answers
	always @(posedge SYS_CLK) begin
		wd_q <= WDATA;
		wd2_q <= wd_q;
	end
	sequence s_sec;
		SECURITY_SET [*5];
	endsequence
	property p_rd_zero;
		!$past(RD) |-> RDATA == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data outside read slot");
	property p_fetch;
		s_sec |=> $stable(EXT_FETCH_LOCK);
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch lock changed while secured");
	property p_boot_keep;
		s_sec |=> $stable(BOOT_AREA);
	endproperty
	a_boot_keep: assert property (p_boot_keep)
		else $error("boot field changed while secured");
	property p_user_protection_fuse;
		s_sec |=> $stable(USER_PROT_EN);
	endproperty
	a_user_protection_fuse: assert property (p_user_protection_fuse)
		else $error("user protection changed while secured");
	property p_sdbg;
		SECURE_DEBUG_EN |-> SECURE_EN;
	endproperty
	a_sdbg: assert property (p_sdbg)
		else $error("secure debug without secure state");
	property p_skeep;
		SECURE_EN |=> SECURE_EN && $stable(SECURE_DEBUG_EN);
	endproperty
	a_skeep: assert property (p_skeep)
		else $error("secure fuses changed in secure mode");
	property p_pop;
		PAGE_OP |-> $past(WR, 2) && $past(ADDR, 2) == 8'h04
			&& wd2_q[31:24] == 8'hA5;
	endproperty
	a_pop: assert property (p_pop)
		else $error("page pulse without keyed command");
	property p_pfld;
		PAGE_OP |-> PAGE_OP_NUM == wd2_q[23:8]
			&& PAGE_OP_ERASE == (wd2_q[5:0] == 6'h02);
	endproperty
	a_pfld: assert property (p_pfld)
		else $error("page pulse fields wrong");
	property p_boot;
		PAGE_OP |-> BOOT_AREA == 3'h7
			|| PAGE_OP_NUM >= (16'h0002 << (3'h6 - BOOT_AREA));
	endproperty
	a_boot: assert property (p_boot)
		else $error("page pulse inside boot area");
	c_pop: cover property (PAGE_OP);
	c_sec: cover property (SECURE_EN);
	c_boot: cover property (PAGE_OP && BOOT_AREA != 3'h7);
endmodule
bind fuse_lock_ctrl fuse_lock_chk i_fuse_lock_chk (.SYS_CLK(SYS_CLK),
	.RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.SECURITY_SET(SECURITY_SET), .RDATA(RDATA),
	.EXT_FETCH_LOCK(EXT_FETCH_LOCK), .BOOT_AREA(BOOT_AREA),
	.SECURE_EN(SECURE_EN), .SECURE_DEBUG_EN(SECURE_DEBUG_EN),
	.USER_PROT_EN(USER_PROT_EN), .PAGE_OP(PAGE_OP),
	.PAGE_OP_NUM(PAGE_OP_NUM), .PAGE_OP_ERASE(PAGE_OP_ERASE));
`default_nettype wire

//--- tb/fuse_lock_ctrl_tb.sv
// testbench for fuse_lock_ctrl: commands, status and fuse reads
// assumes one-cycle command execution and read data one cycle late
`timescale 1ns/1ps
`default_nettype none
module fuse_lock_ctrl_tb;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, sec = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, r;
	logic efl, sen, sdbg, upr, pop, perase;
	logic [2:0] boot;
	logic [15:0] pnum;
	int n_mismatch = 0, checks_done = 0, i;
	// refused while secured: {page number field, code}
	logic [21:0] tbl [5] = '{{16'd16, 6'h08}, {16'd17, 6'h07},
		{16'd22, 6'h07}, {16'h07FA, 6'h0A}, {16'h0, 6'h0B}};
	always #5 clk = ~clk;
	fuse_lock_ctrl i_fuse_lock_ctrl (.SYS_CLK(clk), .RST_N(rst_n),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .SECURITY_SET(sec),
		.RDATA(rdata), .EXT_FETCH_LOCK(efl), .BOOT_AREA(boot),
		.SECURE_EN(sen), .SECURE_DEBUG_EN(sdbg), .USER_PROT_EN(upr),
		.PAGE_OP(pop), .PAGE_OP_NUM(pnum), .PAGE_OP_ERASE(perase));
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wrt(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 r = rdata;
	endtask
	task cmd(input logic [15:0] p, input logic [5:0] c);
		wrt(8'h04, {8'hA5, p, 2'h0, c});
	endtask
	task st(input logic [1:0] e);
		rdr(8'h08);
		chk("status", {30'h0, e}, {30'h0, r[3:2]});
	endtask
	task fu(input logic [31:0] e);
		rdr(8'h18);
		chk("fuse_lo", e, r);
	endtask
	// decoded outputs move one edge after the command executes
	task out(input logic [6:0] e);
		repeat (2) @(posedge clk);
		#1 chk("outs", {25'h0, e}, {25'h0, efl, boot, sen, sdbg, upr});
	endtask
	// page pulse stands in the second cycle after the command write
	task pg(input logic [15:0] n, input logic e, input logic p);
		@(posedge clk);
		#1 chk("page_op", {14'h0, n, e, p}, {14'h0, pnum, perase, pop});
	endtask
	task rst;
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		rst();
		fu(32'hFFFFFFFF);
		rdr(8'h14);
		chk("fuse_hi", 32'hFFFFFFFF, r);
		out(7'h79);
		$display("test reset done");
		cmd(16'd10, 6'h04);
		cmd(16'd1023, 6'h04);
		fu(32'hFFFF7FFE);
		rdr(8'h08);
		chk("status_word", 32'h7FFE0001, {r[31:16], 11'h0, r[4:0]});
		cmd(16'd5, 6'h01);
		pg(16'd5, 1'b0, 1'b0);
		st(2'b01);
		cmd(16'd64, 6'h02);
		pg(16'd64, 1'b1, 1'b1);
		st(2'b00);
		cmd(16'd0, 6'h08);
		cmd(16'd1000, 6'h05);
		cmd(16'd3, 6'h07);
		fu(32'hFFFFFFF7);
		cmd(16'd200, 6'h01);
		st(2'b01);
		wrt(8'h04, 32'h5A000404);
		st(2'b10);
		cmd(16'd0, 6'h0C);
		st(2'b10);
		fu(32'hFFFFFFF7);
		$display("test locks done");
		cmd({5'h0, 8'h12, 3'h3}, 6'h0A);
		cmd({5'h0, 8'hF2, 3'h2}, 6'h0A);
		fu(32'h12F2FFF7);
		out(7'h09);
		cmd(16'd63, 6'h02);
		pg(16'd63, 1'b1, 1'b0);
		st(2'b01);
		cmd(16'd64, 6'h02);
		pg(16'd64, 1'b1, 1'b1);
		st(2'b00);
		$display("test fuse bytes done");
		sec <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 5; i++) begin
			cmd(tbl[i][21:6], tbl[i][5:0]);
			st(2'b01);
		end
		chk("secure_bit", 32'h1, {31'h0, r[4]});
		fu(32'h12F2FFF7);
		out(7'h09);
		sec <= 1'b0;
		repeat (3) @(posedge clk);
		cmd(16'd0, 6'h0B);
		fu(32'hFFFFFFFF);
		cmd(16'd20, 6'h07);
		out(7'h7D);
		cmd(16'd21, 6'h07);
		st(2'b01);
		cmd(16'd0, 6'h0B);
		st(2'b01);
		rst();
		cmd(16'd21, 6'h07);
		out(7'h7F);
		$display("test security done");
		stop_test();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
